// File: design/gpab_pkg.sv
// Constants, register map and carrier types for the two-port GPIO block.
// Assumes a classic Wishbone slave with 32-bit data, one word per register.
// ****************************************************************
// Summary of operation
// ****************************************************************
package gpab_pkg;
    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] GPAB_IDX_PA_DATA = 8'h05; // Port A pins/latch
    localparam logic [7:0] GPAB_IDX_PB_DATA = 8'h06; // Port B pins/latch
    localparam logic [7:0] GPAB_IDX_OPTION = 8'h81; // Option register
    localparam logic [7:0] GPAB_IDX_PA_DIR = 8'h85; // Port A direction
    localparam logic [7:0] GPAB_IDX_PB_DIR = 8'h86; // Port B direction
    localparam logic [7:0] GPAB_IDX_ANCFG = 8'h9f; // Analog pin config
    localparam logic [7:0] GPAB_IDX_INTCTL = 8'h0b; // Interrupt control
    localparam logic [7:0] GPAB_IDX_SLEEP = 8'h0c; // Sleep control
    // Field positions
    localparam int GPAB_PU_DIS_BIT = 7; // Pull-up disable, active high
    localparam int GPAB_CHG_FLAG_BIT = 0; // Port change flag
    localparam int GPAB_CHG_EN_BIT = 3; // Port change enable
    localparam int GPAB_TMR_PIN = 4; // Timer clock pin of port A
    localparam int GPAB_SS_PIN = 5; // Slave select pin of port A
    localparam int GPAB_EXT_PIN = 0; // External interrupt pin of port B
    localparam int GPAB_PGC_PIN = 6; // Programming clock pin
    localparam int GPAB_PGD_PIN = 7; // Programming data pin
    // Reset values
    localparam logic [5:0] GPAB_PA_DIR_RST = 6'h3f;
    localparam logic [7:0] GPAB_PB_DIR_RST = 8'hff;
    localparam logic [7:0] GPAB_OPTION_RST = 8'hff;
    localparam logic [2:0] GPAB_ANCFG_RST = 3'h0;
    localparam logic [7:0] GPAB_INTCTL_RST = 8'h00;
    localparam logic [31:0] GPAB_UNMAPPED = 32'h0000_0000;
    // Analog configuration code that leaves all port A pins digital
    localparam logic [2:0] GPAB_ANCFG_DIGITAL = 3'h6;

    // Wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr; // Byte address
        logic [31:0] dat;
    } gpab_wb_req_t;

    // Pin group carrier: input, output and output enable (low drives)
    typedef struct packed {
        logic [7:0] din;
        logic [7:0] dout;
        logic [7:0] oe_n;
    } gpab_pins_t;
endpackage

// File: design/gpab_top.sv
// GPIO ports A and B with interrupt-on-change and Wishbone registers.
// Assumes pin inputs are synchronous to mclk; pads resolve level from oe_n.
//
// Added by the designer: the Wishbone interface to the registers.
module gpab_top #(
    parameter bit HAS_ANALOG = 1'b1 // Analog-converter variant
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic por_n, // Power-on reset marker, low on power-on
    input wire gpab_pkg::gpab_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] pa_din,
    output logic [5:0] pa_dout,
    output logic [5:0] pa_oe_n,
    input wire logic [7:0] pb_din,
    output logic [7:0] pb_dout,
    output logic [7:0] pb_oe_n,
    output logic [7:0] pb_pullup_en,
    output logic [2:0] analog_pin_configuration,
    output logic timer_zero_clock_pin,
    output logic slave_select_pin,
    output logic external_interrupt_pin,
    output logic prog_clk_in,
    output logic prog_data_in,
    output logic port_change_flag,
    output logic port_change_irq,
    output logic wake_n
);
    import gpab_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [5:0] pa_latch_r; // Port A output latch
    logic [5:0] port_a_direction_r; // One bit per pin, 1 = input
    logic [7:0] pb_latch_r; // Port B output latch
    logic [7:0] port_b_direction_r; // 1 = input
    logic [7:0] option_r; // Option register
    logic [2:0] ancfg_r; // Analog pin configuration
    logic [7:0] intctl_r; // Interrupt control register
    logic sleep_r; // Sleep request
    logic [3:0] chg_copy_r; // Levels of bits 7:4 at last access
    logic ack_r; // Bus acknowledge
    logic [31:0] rdat_r; // Read data
    logic pu_off_r; // Pull-ups held off since power-on

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic req; // New access this cycle
    logic wr; // Write access
    logic [7:0] idx; // Register index
    logic pb_access; // Any port B data access
    logic [3:0] mismatch; // Per-pin change
    logic chg_any; // OR of mismatches
    logic [5:0] analog_mask; // Port A pins in analog mode

    // Word index from byte address
    function automatic logic [7:0] word_idx(input logic [9:0] a);
        return a[9:2];
    endfunction

    // Lane-merge a byte into an old value using sel bit 0
    function automatic logic [7:0] merge8(input logic [7:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        return s[0] ? d[7:0] : o;
    endfunction

    assign req = wb_req.cyc && wb_req.stb && !ack_r;
    assign wr = req && wb_req.we;
    assign idx = word_idx(wb_req.adr);
    assign pb_access = req && (idx == GPAB_IDX_PB_DATA);

    // Analog pins: code 000 makes 0,1,2,3,5 analog
    always_comb begin
        analog_mask = 6'h00;
        if (HAS_ANALOG && ancfg_r != GPAB_ANCFG_DIGITAL) begin
            analog_mask = 6'h2f;
        end
    end

    // ****************************************************************
    // Port A registers
    // ****************************************************************
    // Direction resets to all ones on every reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_direction_r <= GPAB_PA_DIR_RST;
        end else if (wr && idx == GPAB_IDX_PA_DIR && wb_req.sel[0]) begin
            port_a_direction_r <= wb_req.dat[5:0];
        end
    end

    // Output latch; write updates latch only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pa_latch_r <= 6'h00;
        end else if (wr && idx == GPAB_IDX_PA_DATA && wb_req.sel[0]) begin
            pa_latch_r <= wb_req.dat[5:0];
        end
    end

    // Analog configuration, only in the analog variant
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ancfg_r <= GPAB_ANCFG_RST;
        end else if (HAS_ANALOG && wr && idx == GPAB_IDX_ANCFG
                     && wb_req.sel[0]) begin
            ancfg_r <= wb_req.dat[2:0];
        end
    end

    // ****************************************************************
    // Port B registers
    // ****************************************************************
    // Direction resets to all ones
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_direction_r <= GPAB_PB_DIR_RST;
        end else if (wr && idx == GPAB_IDX_PB_DIR) begin
            port_b_direction_r <= merge8(port_b_direction_r, wb_req.dat,
                                         wb_req.sel);
        end
    end

    // Output latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pb_latch_r <= 8'h00;
        end else if (wr && idx == GPAB_IDX_PB_DATA) begin
            pb_latch_r <= merge8(pb_latch_r, wb_req.dat, wb_req.sel);
        end
    end

    // Option register; pull-up disable bit reset high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            option_r <= GPAB_OPTION_RST;
        end else if (wr && idx == GPAB_IDX_OPTION) begin
            option_r <= merge8(option_r, wb_req.dat, wb_req.sel);
        end
    end

    // Pull-ups stay off after a power-on reset until option is written
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pu_off_r <= 1'b1;
        end else if (!por_n) begin
            pu_off_r <= 1'b1;
        end else if (wr && idx == GPAB_IDX_OPTION) begin
            pu_off_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Change detection
    // ****************************************************************
    // Mismatch only on inputs among bits 7:4
    assign mismatch = (pb_din[7:4] ^ chg_copy_r)
                      & port_b_direction_r[7:4];
    assign chg_any = |mismatch;

    // Copy refreshed by any port B data access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chg_copy_r <= 4'h0;
        end else if (pb_access) begin
            chg_copy_r <= pb_din[7:4];
        end
    end

    // Interrupt control; the set from a mismatch wins over a clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intctl_r <= GPAB_INTCTL_RST;
        end else begin
            if (wr && idx == GPAB_IDX_INTCTL && wb_req.sel[0]) begin
                intctl_r <= wb_req.dat[7:0];
            end
            if (chg_any) begin
                intctl_r[GPAB_CHG_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Sleep request, ended by a port change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_r <= 1'b0;
        end else if (intctl_r[GPAB_CHG_FLAG_BIT]) begin
            sleep_r <= 1'b0;
        end else if (wr && idx == GPAB_IDX_SLEEP && wb_req.sel[0]) begin
            sleep_r <= wb_req.dat[0];
        end
    end

    // ****************************************************************
    // Read data and acknowledge
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_r <= GPAB_UNMAPPED;
        end else if (req) begin
            case (idx)
                GPAB_IDX_PA_DATA: // Pins, analog pins read zero
                    rdat_r <= {26'h0, pa_din & ~analog_mask};
                GPAB_IDX_PA_DIR:
                    rdat_r <= {26'h0, port_a_direction_r};
                GPAB_IDX_PB_DATA:
                    rdat_r <= {24'h0, pb_din};
                GPAB_IDX_PB_DIR:
                    rdat_r <= {24'h0, port_b_direction_r};
                GPAB_IDX_OPTION:
                    rdat_r <= {24'h0, option_r};
                GPAB_IDX_ANCFG:
                    rdat_r <= HAS_ANALOG ? {29'h0, ancfg_r} : GPAB_UNMAPPED;
                GPAB_IDX_INTCTL:
                    rdat_r <= {24'h0, intctl_r};
                GPAB_IDX_SLEEP:
                    rdat_r <= {31'h0, sleep_r};
                default:
                    rdat_r <= GPAB_UNMAPPED;
            endcase
        end
    end

    // One-cycle ack one cycle after request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always_comb begin
        pa_dout = pa_latch_r;
        pa_oe_n = port_a_direction_r | analog_mask;
        // Open-drain: only drive when latch is low
        pa_dout[GPAB_TMR_PIN] = 1'b0;
        pa_oe_n[GPAB_TMR_PIN] = port_a_direction_r[GPAB_TMR_PIN]
                                | pa_latch_r[GPAB_TMR_PIN];
    end

    assign pb_dout = pb_latch_r;
    assign pb_oe_n = port_b_direction_r;
    // Pull-up on only for inputs with disable bit clear
    assign pb_pullup_en = (pu_off_r || option_r[GPAB_PU_DIS_BIT])
                          ? 8'h00 : port_b_direction_r;

    // Alternate functions; Schmitt buffering lives in the pad
    assign timer_zero_clock_pin = pa_din[GPAB_TMR_PIN];
    assign slave_select_pin = pa_din[GPAB_SS_PIN];
    assign external_interrupt_pin = pb_din[GPAB_EXT_PIN];
    assign prog_clk_in = pb_din[GPAB_PGC_PIN];
    assign prog_data_in = pb_din[GPAB_PGD_PIN];
    assign analog_pin_configuration = ancfg_r;
    assign port_change_flag = intctl_r[GPAB_CHG_FLAG_BIT];
    assign port_change_irq = intctl_r[GPAB_CHG_FLAG_BIT]
                             & intctl_r[GPAB_CHG_EN_BIT];
    assign wake_n = !sleep_r;
    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_flag_on_mismatch: assert property (
        @(posedge mclk) disable iff (!rst_n)
        chg_any |=> port_change_flag)
        else $error("mismatch did not set flag");
    a_access_ends_mismatch: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pb_access && $stable(pb_din) ##1 $stable(pb_din) |-> !chg_any)
        else $error("port access did not end mismatch");
    a_output_excluded: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (port_b_direction_r[7:4] == 4'h0) |-> !chg_any)
        else $error("output pin caused change");
    a_pullup_output_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (pb_pullup_en & ~port_b_direction_r) == 8'h00)
        else $error("pull-up on output pin");
    a_pb_drive_latch: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ((pb_dout ^ pb_latch_r) | (pb_oe_n ^ port_b_direction_r)) == 8'h00)
        else $error("port B drive wrong");
    a_od_never_high: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !pa_oe_n[GPAB_TMR_PIN] |-> !pa_dout[GPAB_TMR_PIN])
        else $error("open-drain pin drove high");
    a_ack_one_cycle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    a_flag_wakes: assert property (
        @(posedge mclk) disable iff (!rst_n)
        port_change_flag |=> wake_n)
        else $error("change did not wake");
    a_pullup_por_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !por_n |=> pb_pullup_en == 8'h00)
        else $error("pull-up on after power-on");

    c_change_flag: cover property (@(posedge mclk) disable iff (!rst_n)
        !port_change_flag ##1 port_change_flag);
    c_wake: cover property (@(posedge mclk) disable iff (!rst_n)
        sleep_r ##1 !sleep_r);
    c_pb_read: cover property (@(posedge mclk) disable iff (!rst_n)
        pb_access && !wb_req.we);
endmodule

// File: test/gpab_pad_model.sv
// Pad model: resolves the port pin levels that the GPIO block sees.
// Assumes the bench changes its external levels just after mclk edges.
module gpab_pad_model (
    input wire logic mclk,
    input wire logic [5:0] pa_dout,
    input wire logic [5:0] pa_oe_n,
    input wire logic [7:0] pb_dout,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pb_pullup_en,
    input wire logic [5:0] pa_ext,
    input wire logic [5:0] pa_ext_en,
    input wire logic [7:0] pb_ext,
    input wire logic [7:0] pb_ext_en,
    output logic [5:0] pa_din,
    output logic [7:0] pb_din
);
    timeunit 1ns;
    timeprecision 100ps;
    // **********************************************
    // Pin resolution
    // **********************************************
    logic [7:0] flt_r = 8'h00; // Level of an undriven pin, flips each cycle
    // A floating pin must not look like a stable level
    always_ff @(posedge mclk) begin
        flt_r <= ~flt_r;
    end
    // Block drive wins, then the external resistor, then the weak pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pb_oe_n[i]) pb_din[i] = pb_dout[i];
            else if (pb_ext_en[i]) pb_din[i] = pb_ext[i];
            else if (pb_pullup_en[i]) pb_din[i] = 1'b1;
            else pb_din[i] = flt_r[i];
        end
        // Port A has no pull-ups; an open-drain high floats unless pulled
        for (int i = 0; i < 6; i++) begin
            if (!pa_oe_n[i]) pa_din[i] = pa_dout[i];
            else if (pa_ext_en[i]) pa_din[i] = pa_ext[i];
            else pa_din[i] = flt_r[i];
        end
    end
endmodule

// File: test/gpio_ports_a_b_change_irq_tb.sv
// Testbench for the two-port GPIO block over its Wishbone registers.
// Assumes the pad model stands between the block's pins and the bench.
module gpio_ports_a_b_change_irq_tb import gpab_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // **********************************************
    // Signals and instances
    // **********************************************
    logic mclk = 1'b0, rst_n = 1'b0, por_n = 1'b0;
    gpab_wb_req_t wb_req = '0; // Bus request, driven on rising edges
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [5:0] pa_din, pa_dout, pa_oe_n;
    logic [5:0] pa_ext = 6'h3f, pa_ext_en = 6'h3f; // External port A drive
    logic [7:0] pb_din, pb_dout, pb_oe_n, pb_pullup_en;
    logic [7:0] pb_ext = 8'h00, pb_ext_en = 8'h00; // External port B drive
    logic [2:0] analog_pin_configuration;
    logic timer_zero_clock_pin, slave_select_pin, external_interrupt_pin;
    logic prog_clk_in, prog_data_in, port_change_flag, port_change_irq;
    logic wake_n;
    int num_errors = 0, total_checks = 0;
    gpab_top #(.HAS_ANALOG(1'b1)) DUT (.mclk, .rst_n, .por_n, .wb_req,
        .wb_dat_o, .wb_ack_o, .pa_din, .pa_dout, .pa_oe_n, .pb_din,
        .pb_dout, .pb_oe_n, .pb_pullup_en, .analog_pin_configuration,
        .timer_zero_clock_pin, .slave_select_pin, .external_interrupt_pin,
        .prog_clk_in, .prog_data_in, .port_change_flag, .port_change_irq,
        .wake_n);
    gpab_pad_model u_pads (.mclk, .pa_dout, .pa_oe_n, .pb_dout, .pb_oe_n,
        .pb_pullup_en, .pa_ext, .pa_ext_en, .pb_ext, .pb_ext_en, .pa_din,
        .pb_din);
    // **********************************************
    // Tasks
    // **********************************************
    // One compare, counted and reported
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic single cycle: hold until ack, take data, then release
    task automatic wb_cyc(input logic we, input logic [7:0] idx,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1,
                    adr: {idx, 2'b00}, dat: d};
        // Waits for ack; only the watchdog ends a wait that gets no answer
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_req <= '0;
        #1;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb_cyc(1'b1, idx, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] idx,
                      input logic [31:0] e);
        logic [31:0] q;
        wb_cyc(1'b0, idx, 32'h0, q);
        chk(nm, e, q);
    endtask
    // Let n edges pass and their updates settle
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // **********************************************
    // Clock, watchdog and tests
    // **********************************************
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // Cuts a hang short well after the tests should have ended
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        $display("ERROR watchdog expected done seen timeout");
        close_out();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        wait_cyc(1);
        // Reset state, power-on still in progress
        chk("pa_oe_n", 32'h3f, pa_oe_n);
        chk("pb_oe_n", 32'hff, pb_oe_n);
        rd("pa_dir", GPAB_IDX_PA_DIR, 32'h3f);
        rd("pb_dir", GPAB_IDX_PB_DIR, 32'hff);
        rd("ancfg", GPAB_IDX_ANCFG, 32'h0);
        rd("pa_data", GPAB_IDX_PA_DATA, 32'h10);
        wr(GPAB_IDX_OPTION, 32'h7f);
        chk("pullup_por", 32'h0, pb_pullup_en);
        // Pull-ups, direction and latch drive
        @(posedge mclk);
        por_n <= 1'b1;
        wr(GPAB_IDX_OPTION, 32'h7f);
        chk("pullup_on", 32'hff, pb_pullup_en);
        wr(GPAB_IDX_PB_DIR, 32'h0f);
        chk("pb_oe_n", 32'h0f, pb_oe_n);
        chk("pullup_out", 32'h0f, pb_pullup_en);
        wr(GPAB_IDX_PB_DATA, 32'ha5);
        chk("pb_dout", 32'ha5, pb_dout);
        rd("pb_data", GPAB_IDX_PB_DATA, 32'haf);
        wr(GPAB_IDX_OPTION, 32'hff);
        chk("pullup_off", 32'h0, pb_pullup_en);
        // Interrupt on change; port B is not polled meanwhile
        @(posedge mclk);
        pb_ext_en <= 8'hff;
        wr(GPAB_IDX_PB_DIR, 32'hff);
        rd("pb_data", GPAB_IDX_PB_DATA, 32'h0);
        wr(GPAB_IDX_INTCTL, 32'h08);
        wr(GPAB_IDX_SLEEP, 32'h01);
        wait_cyc(2);
        chk("flag_idle", 32'h0, port_change_flag);
        chk("wake_n_sleep", 32'h0, wake_n);
        @(posedge mclk);
        pb_ext <= 8'h20;
        wait_cyc(3);
        chk("flag_set", 32'h1, port_change_flag);
        chk("irq", 32'h1, port_change_irq);
        chk("wake_n_wake", 32'h1, wake_n);
        rd("intctl", GPAB_IDX_INTCTL, 32'h09);
        wr(GPAB_IDX_INTCTL, 32'h08);
        chk("flag_kept", 32'h1, port_change_flag);
        rd("pb_data", GPAB_IDX_PB_DATA, 32'h20);
        wait_cyc(2);
        chk("flag_sticky", 32'h1, port_change_flag);
        wr(GPAB_IDX_INTCTL, 32'h08);
        wait_cyc(3);
        chk("flag_clear", 32'h0, port_change_flag);
        @(posedge mclk);
        pb_ext <= 8'h24;
        wait_cyc(3);
        chk("flag_low_bit", 32'h0, port_change_flag);
        // An output pin among bits 4-7 is left out of the compare
        wr(GPAB_IDX_PB_DATA, 32'h10);
        wr(GPAB_IDX_PB_DIR, 32'hef);
        wait_cyc(3);
        chk("pb_din", 32'h34, pb_din);
        chk("flag_output", 32'h0, port_change_flag);
        // Alternate input functions follow their pins
        @(posedge mclk);
        pb_ext <= 8'h41;
        pa_ext_en <= 6'h10;
        pa_ext <= 6'h10;
        wait_cyc(2);
        chk("pb_alt", 32'h6, {external_interrupt_pin, prog_clk_in,
            prog_data_in});
        // Port A digital use, open-drain bit 4
        wr(GPAB_IDX_ANCFG, {29'h0, GPAB_ANCFG_DIGITAL});
        rd("ancfg", GPAB_IDX_ANCFG, {29'h0, GPAB_ANCFG_DIGITAL});
        chk("ancfg_out", 32'h6, analog_pin_configuration);
        wr(GPAB_IDX_PA_DIR, 32'hff);
        rd("pa_dir", GPAB_IDX_PA_DIR, 32'h3f);
        wr(GPAB_IDX_PA_DIR, 32'h00);
        wr(GPAB_IDX_PA_DATA, 32'hff);
        chk("pa_oe_n", 32'h10, pa_oe_n);
        chk("pa_dout", 32'h2f, pa_dout);
        rd("pa_data", GPAB_IDX_PA_DATA, 32'h3f);
        chk("pa_alt", 32'h3, {timer_zero_clock_pin,
            slave_select_pin});
        wr(GPAB_IDX_PA_DATA, 32'h00);
        chk("pa_oe_n", 32'h00, pa_oe_n);
        rd("pa_data", GPAB_IDX_PA_DATA, 32'h00);
        // Unmapped index reads zero and ignores writes
        wr(8'h40, 32'hff);
        rd("unmapped", 8'h40, GPAB_UNMAPPED);
        // Second reset in mid-run
        @(posedge mclk);
        rst_n <= 1'b0;
        wait_cyc(2);
        rst_n <= 1'b1;
        wait_cyc(1);
        chk("pa_oe_n", 32'h3f, pa_oe_n);
        rd("pa_dir", GPAB_IDX_PA_DIR, 32'h3f);
        rd("pb_dir", GPAB_IDX_PB_DIR, 32'hff);
        close_out();
    end
endmodule
